// *** hdl/tmu_pkg.sv ***
// Constants shared by the measurement routing and channel status block.
// Assumes a 32-bit AXI4-Lite host and four timing channels.
// Contract
// - Arm output tristated unless routing bit 3 set.
// - Selector code picks channel code/2, high or low.
// - Routing bits 2:0 select arm source, reset zero.
// - Bit 11 enables stop; bits 10:8 select source.
// - Bit 7 enables start; enables reset zero.
// - Bits 6:4 select the start source.
// - Multiplex bit 1 folds channel 3 onto 2.
// - Multiplex bit 0 folds channel 1 onto 0.
// - Status 15:12 are per-channel fail summaries.
// - Status 11:8 are per-channel timing error summaries.
// - Odd status bits 7..1 show live high comparators.
// - Even status bits 6..0 show live low comparators.
// - Three independent selectors for arm, start, stop.
package tmu_pkg;
    // Register indices; the byte address is four times the index.
    localparam logic [5:0] IDX_ROUTE   = 6'h1c;
    localparam logic [5:0] IDX_MUX     = 6'h1d;
    localparam logic [5:0] IDX_STAT    = 6'h1e;
    localparam logic [5:0] IDX_CHIP    = 6'h1f;
    localparam logic [5:0] IDX_IRQ_ST  = 6'h20;
    localparam logic [5:0] IDX_IRQ_MSK = 6'h21;
    // Routing register field positions.
    localparam int ARM_SEL_LSB   = 0;
    localparam int ARM_EN_BIT    = 3;
    localparam int START_SEL_LSB = 4;
    localparam int START_EN_BIT  = 7;
    localparam int STOP_SEL_LSB  = 8;
    localparam int STOP_EN_BIT   = 11;
    localparam int ROUTE_W       = 12;
    localparam logic [11:0] ROUTE_RST = 12'h000;
    // Multiplex enable register fields.
    localparam int MUX_LOWER_BIT = 0;
    localparam int MUX_UPPER_BIT = 1;
    localparam int MUX_W         = 2;
    localparam logic [1:0] MUX_RST = 2'h0;
    // Event status layout: fails in 7:4, timing errors in 3:0.
    localparam int EVT_W = 8;
    localparam logic [7:0] EVT_RST = 8'h00;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Code n picks channel n/2; even codes the high comparator.
    function automatic logic route_pick(input logic [2:0] code,
                                        input logic [3:0] hi,
                                        input logic [3:0] lo);
        route_pick = code[0] ? lo[code[2:1]] : hi[code[2:1]];
    endfunction

    // Interleave comparators: high in odd bits, low in even bits.
    function automatic logic [7:0] cmp_word(input logic [3:0] hi,
                                            input logic [3:0] lo);
        cmp_word = {hi[3], lo[3], hi[2], lo[2],
                    hi[1], lo[1], hi[0], lo[0]};
    endfunction
endpackage

// *** hdl/tmu_route_sel.sv ***
// One routing selector feeding a measurement line with its enable.
// Assumes comparator levels synchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
module tmu_route_sel
    import tmu_pkg::*;
(
    input  wire logic       core_clk,  // System clock.
    input  wire logic       rst,       // Async reset, active high.
    input  wire logic [2:0] sel,       // Source code.
    input  wire logic       en,        // Drive enable.
    input  wire logic [3:0] comp_high, // High comparator levels.
    input  wire logic [3:0] comp_low,  // Low comparator levels.
    output logic            line_q,    // Registered routed level.
    output logic            oe_q       // Registered output enable.
);
    logic line_d;
    logic oe_d;

    // Output is held low while disabled so the pad sees no toggling.
    always_comb begin
        oe_d   = en;
        line_d = en ? route_pick(sel, comp_high, comp_low) : 1'b0;
    end

    // Register line and enable together so they never skew.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            line_q <= 1'b0;
            oe_q   <= 1'b0;
        end else begin
            line_q <= line_d;
            oe_q   <= oe_d;
        end
    end
endmodule
`default_nettype wire

// *** hdl/tmu_evt_status.sv ***
// Sticky event status with mask and one level interrupt.
// Assumes event inputs are levels synchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
module tmu_evt_status
    import tmu_pkg::*;
(
    input  wire logic             core_clk, // System clock.
    input  wire logic             rst,      // Async reset, active high.
    input  wire logic [EVT_W-1:0] evt,      // Event levels.
    input  wire logic [EVT_W-1:0] mask,     // Interrupt enables.
    input  wire logic             rd_clr,   // Status read pulse.
    output logic [EVT_W-1:0]      stat_q,   // Sticky status bits.
    output logic                  irq_q     // Level interrupt.
);
    logic [EVT_W-1:0] prev_q;
    logic [EVT_W-1:0] prev_d;
    logic [EVT_W-1:0] stat_d;
    logic             irq_d;

    // A rising event beats a clearing read in the same cycle.
    always_comb begin
        prev_d = evt;
        stat_d = (rd_clr ? EVT_RST : stat_q) | (evt & ~prev_q);
        irq_d  = |(stat_d & mask);
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prev_q <= EVT_RST;
            stat_q <= EVT_RST;
            irq_q  <= 1'b0;
        end else begin
            prev_q <= prev_d;
            stat_q <= stat_d;
            irq_q  <= irq_d;
        end
    end
endmodule
`default_nettype wire

// *** hdl/tmu_regs.sv ***
// Measurement routing and channel status registers, AXI4-Lite slave.
// Assumes all inputs synchronous to core_clk; pads resolve the enables.
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module tmu_regs
    import tmu_pkg::*;
#(
    parameter int          ADDR_W    = 8,      // Byte address width.
    parameter logic [15:0] CHIP_INFO = 16'h0000 // Arbitrary value.
) (
    input  wire logic        core_clk,        // System clock.
    input  wire logic        rst,             // Async reset, high.
    input  wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address.
    input  wire logic        s_axi_awvalid,   // Write address valid.
    output logic             s_axi_awready,   // Write address ready.
    input  wire logic [31:0] s_axi_wdata,     // Write data.
    input  wire logic [3:0]  s_axi_wstrb,     // Write byte enables.
    input  wire logic        s_axi_wvalid,    // Write data valid.
    output logic             s_axi_wready,    // Write data ready.
    output logic [1:0]       s_axi_bresp,     // Write response.
    output logic             s_axi_bvalid,    // Write response valid.
    input  wire logic        s_axi_bready,    // Write response ready.
    input  wire logic [ADDR_W-1:0] s_axi_araddr, // Read address.
    input  wire logic        s_axi_arvalid,   // Read address valid.
    output logic             s_axi_arready,   // Read address ready.
    output logic [31:0]      s_axi_rdata,     // Read data.
    output logic [1:0]       s_axi_rresp,     // Read response.
    output logic             s_axi_rvalid,    // Read data valid.
    input  wire logic        s_axi_rready,    // Read data ready.
    input  wire logic [3:0]  comp_high,       // High comparators.
    input  wire logic [3:0]  comp_low,        // Low comparators.
    input  wire logic [3:0]  fail_any,        // Fail register OR.
    input  wire logic [3:0]  timing_err,      // Timing error OR.
    output logic             measure_arm_out,   // Arm level.
    output logic             measure_arm_oe,    // Arm enable.
    output logic             measure_start_out, // Start level.
    output logic             measure_start_oe,  // Start enable.
    output logic             measure_stop_out,  // Stop level.
    output logic             measure_stop_oe,   // Stop enable.
    output logic             lower_pair_mux_enable, // Ch1 onto ch0.
    output logic             upper_pair_mux_enable, // Ch3 onto ch2.
    output logic             irq                // Level interrupt.
);
    if (ADDR_W < 8 || ADDR_W > 32) begin : g_chk
        $error("ADDR_W must be 8 to 32");
    end

    logic [ROUTE_W-1:0] route_q, route_d;
    logic [MUX_W-1:0]   mux_q, mux_d;
    logic [EVT_W-1:0]   mask_q, mask_d;
    logic               aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic [5:0]         widx_q, widx_d;
    logic [31:0]        wdata_q, wdata_d;
    logic [3:0]         wstrb_q, wstrb_d;
    logic               awready_d, wready_d, bvalid_d, arready_d;
    logic               rvalid_d;
    logic [1:0]         bresp_d, rresp_d;
    logic [31:0]        rdata_d;
    logic               rd_clr;
    logic [EVT_W-1:0]   evt_stat;
    logic [5:0]         ridx;

    assign ridx = s_axi_araddr[7:2];

    // Decode an index to its read word; unmapped indices flag an error.
    function automatic logic [32:0] read_word(input logic [5:0] idx,
                                              input logic [11:0] rt,
                                              input logic [1:0] mx,
                                              input logic [7:0] st,
                                              input logic [7:0] mk);
        read_word = 33'h000000000;
        case (idx)
            IDX_ROUTE:   read_word[11:0] = rt;
            IDX_MUX:     read_word[1:0]  = mx;
            // Summary bits are live ORs, so a read cannot clear them.
            IDX_STAT:    read_word[15:0] = {fail_any, timing_err,
                cmp_word(comp_high, comp_low)};
            IDX_CHIP:    read_word[15:0] = CHIP_INFO;
            IDX_IRQ_ST:  read_word[7:0]  = st;
            IDX_IRQ_MSK: read_word[7:0]  = mk;
            default:     read_word[32]   = 1'b1;
        endcase
    endfunction

    // Bus handshakes and register writes; address and data may come
    // in either order, and the write lands once both are held.
    always_comb begin
        route_d   = route_q;
        mux_d     = mux_q;
        mask_d    = mask_q;
        aw_have_d = aw_have_q;
        w_have_d  = w_have_q;
        widx_d    = widx_q;
        wdata_d   = wdata_q;
        wstrb_d   = wstrb_q;
        bvalid_d  = s_axi_bvalid && !s_axi_bready;
        bresp_d   = s_axi_bresp;
        rvalid_d  = s_axi_rvalid && !s_axi_rready;
        rresp_d   = s_axi_rresp;
        rdata_d   = s_axi_rdata;
        rd_clr    = 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_have_d = 1'b1;
            widx_d    = s_axi_awaddr[7:2];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_have_d = 1'b1;
            wdata_d  = s_axi_wdata;
            wstrb_d  = s_axi_wstrb;
        end
        if (aw_have_q && w_have_q && !s_axi_bvalid) begin
            aw_have_d = 1'b0;
            w_have_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = RESP_OKAY;
            case (widx_q)
                IDX_ROUTE: begin
                    if (wstrb_q[0]) begin
                        route_d[7:0] = wdata_q[7:0];
                    end
                    if (wstrb_q[1]) begin
                        route_d[11:8] = wdata_q[11:8];
                    end
                end
                IDX_MUX: begin
                    // Only the two pair bits exist; the rest is dropped.
                    if (wstrb_q[0]) begin
                        mux_d = wdata_q[1:0];
                    end
                end
                IDX_IRQ_MSK: begin
                    if (wstrb_q[0]) begin
                        mask_d = wdata_q[7:0];
                    end
                end
                IDX_STAT, IDX_CHIP, IDX_IRQ_ST: bresp_d = RESP_OKAY;
                default: bresp_d = RESP_SLVERR;
            endcase
        end
        if (s_axi_arvalid && s_axi_arready) begin
            {rresp_d[1], rdata_d} = read_word(ridx, route_q, mux_q,
                                              evt_stat, mask_q);
            rresp_d[0] = 1'b0;
            rvalid_d   = 1'b1;
            rd_clr     = (ridx == IDX_IRQ_ST);
        end
        awready_d = !aw_have_d && !bvalid_d;
        wready_d  = !w_have_d && !bvalid_d;
        arready_d = !rvalid_d;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            route_q       <= ROUTE_RST;
            mux_q         <= MUX_RST;
            mask_q        <= EVT_RST;
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            widx_q        <= 6'h00;
            wdata_q       <= 32'h00000000;
            wstrb_q       <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= RESP_OKAY;
            s_axi_rdata   <= 32'h00000000;
        end else begin
            route_q       <= route_d;
            mux_q         <= mux_d;
            mask_q        <= mask_d;
            aw_have_q     <= aw_have_d;
            w_have_q      <= w_have_d;
            widx_q        <= widx_d;
            wdata_q       <= wdata_d;
            wstrb_q       <= wstrb_d;
            s_axi_awready <= awready_d;
            s_axi_wready  <= wready_d;
            s_axi_bvalid  <= bvalid_d;
            s_axi_bresp   <= bresp_d;
            s_axi_arready <= arready_d;
            s_axi_rvalid  <= rvalid_d;
            s_axi_rresp   <= rresp_d;
            s_axi_rdata   <= rdata_d;
        end
    end

    // Pair multiplex enables go straight out of their flip-flops.
    assign lower_pair_mux_enable = mux_q[MUX_LOWER_BIT];
    assign upper_pair_mux_enable = mux_q[MUX_UPPER_BIT];

    // Three separate selectors so each line may pick any source.
    tmu_route_sel u_arm (
        .core_clk  (core_clk),
        .rst       (rst),
        .sel       (route_q[ARM_SEL_LSB +: 3]),
        .en        (route_q[ARM_EN_BIT]),
        .comp_high (comp_high),
        .comp_low  (comp_low),
        .line_q    (measure_arm_out),
        .oe_q      (measure_arm_oe)
    );
    tmu_route_sel u_start (
        .core_clk  (core_clk),
        .rst       (rst),
        .sel       (route_q[START_SEL_LSB +: 3]),
        .en        (route_q[START_EN_BIT]),
        .comp_high (comp_high),
        .comp_low  (comp_low),
        .line_q    (measure_start_out),
        .oe_q      (measure_start_oe)
    );
    tmu_route_sel u_stop (
        .core_clk  (core_clk),
        .rst       (rst),
        .sel       (route_q[STOP_SEL_LSB +: 3]),
        .en        (route_q[STOP_EN_BIT]),
        .comp_high (comp_high),
        .comp_low  (comp_low),
        .line_q    (measure_stop_out),
        .oe_q      (measure_stop_oe)
    );

    // Fail and timing error rises raise the interrupt if enabled in mask_q; reading the
    // event status clears it, the live summary stays untouched.
    tmu_evt_status u_evt (
        .core_clk (core_clk),
        .rst      (rst),
        .evt      ({fail_any, timing_err}),
        .mask     (mask_q),
        .rd_clr   (rd_clr),
        .stat_q   (evt_stat),
        .irq_q    (irq)
    );

    // Checks on routing, multiplex and status behaviour.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_arm_tristate: assert property (
        !route_q[ARM_EN_BIT] |=> !measure_arm_oe && !measure_arm_out)
        else $error("arm line driven while disabled");
    a_arm_source: assert property (
        route_q[ARM_EN_BIT] |=> measure_arm_oe && measure_arm_out ==
        route_pick($past(route_q[2:0]), $past(comp_high), $past(comp_low)))
        else $error("arm line has wrong source");
    a_code_decode: assert property (
        route_q[ARM_EN_BIT] && route_q[2:0] == 3'h5 |=>
        measure_arm_out == $past(comp_low[2]))
        else $error("code five is not channel two low");
    a_stop_source: assert property (
        route_q[STOP_EN_BIT] |=> measure_stop_oe && measure_stop_out ==
        route_pick($past(route_q[10:8]), $past(comp_high), $past(comp_low)))
        else $error("stop line has wrong source");
    a_start_enable: assert property (
        !route_q[START_EN_BIT] |=> !measure_start_oe)
        else $error("start line enabled while bit clear");
    a_start_source: assert property (
        route_q[START_EN_BIT] |=> measure_start_out ==
        route_pick($past(route_q[6:4]), $past(comp_high), $past(comp_low)))
        else $error("start line has wrong source");
    a_mux_upper: assert property (
        $rose(s_axi_bvalid) && widx_q == IDX_MUX && wstrb_q[0] |->
        upper_pair_mux_enable == wdata_q[1])
        else $error("upper pair enable not written");
    a_mux_lower: assert property (
        $rose(s_axi_bvalid) && widx_q == IDX_MUX && wstrb_q[0] |->
        lower_pair_mux_enable == wdata_q[0])
        else $error("lower pair enable not written");
    a_stat_fail: assert property (
        s_axi_arvalid && s_axi_arready && ridx == IDX_STAT |=>
        s_axi_rvalid && s_axi_rdata[15:12] == $past(fail_any))
        else $error("fail summary misread");
    a_stat_terr: assert property (
        s_axi_arvalid && s_axi_arready && ridx == IDX_STAT |=>
        s_axi_rdata[11:8] == $past(timing_err))
        else $error("timing error summary misread");
    a_stat_high: assert property (
        s_axi_arvalid && s_axi_arready && ridx == IDX_STAT |=>
        {s_axi_rdata[7], s_axi_rdata[5], s_axi_rdata[3], s_axi_rdata[1]}
        == $past(comp_high))
        else $error("high comparator misread");
    a_stat_low: assert property (
        s_axi_arvalid && s_axi_arready && ridx == IDX_STAT |=>
        {s_axi_rdata[6], s_axi_rdata[4], s_axi_rdata[2], s_axi_rdata[0]}
        == $past(comp_low))
        else $error("low comparator misread");
    a_mux_unused: assert property (
        s_axi_arvalid && s_axi_arready && ridx == IDX_MUX |=>
        s_axi_rdata[31:2] == 30'h00000000)
        else $error("unused multiplex bits not zero");

    c_arm_routed: cover property (
        route_q[ARM_EN_BIT] ##1 measure_arm_oe && measure_arm_out);
    c_mux_write: cover property ($rose(upper_pair_mux_enable));
    c_irq_raised: cover property ($rose(irq));
endmodule
`default_nettype wire

// *** tb/tmu_board_sel.sv ***
// Board selection logic between this device and the measurement unit.
// Assumes the device drives each line only while its enable is high.
`timescale 1ns/1ps
`default_nettype none
module tmu_board_sel (
    input  wire logic       core_clk, // System clock.
    input  wire logic       dev_sel,  // Board picks this device.
    input  wire logic [2:0] line,     // Stop, start, arm levels.
    input  wire logic [2:0] oe,       // Stop, start, arm enables.
    output logic      [2:0] unit      // Lines reaching the unit.
);
    logic [2:0] last_q = 3'h0;

    // Remember what the unit saw, to model a floating bus.
    always_ff @(posedge core_clk) begin
        last_q <= unit;
    end

    // A released line shows the inverse of its last level, so a stale
    // value can never pass for a driven one.
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            unit[i] = (dev_sel && oe[i]) ? line[i] : ~last_q[i];
        end
    end
endmodule
`default_nettype wire

// *** tb/tmu_select_and_channel_status_test.sv ***
// Self-checking bench for the routing and channel status registers.
// Assumes the board selection model is compiled before this file.
`timescale 1ns/1ps
`default_nettype none
module tmu_select_and_channel_status_test
    import tmu_pkg::*;
;
    typedef struct packed {
        logic [11:0] route;
        logic [3:0]  hi, lo, fail, terr;
        logic [5:0]  outs;
        logic [15:0] stat;
    } tmu_row_t;
    // Every code on every selector, with one line disabled now and then.
    tmu_row_t rows [8] = '{
        '{12'haf8, 4'ha, 4'h5, 4'h0, 4'h7, 6'h2b, 16'h0799},
        '{12'hbe1, 4'ha, 4'h5, 4'h1, 4'h6, 6'h0e, 16'h1699},
        '{12'hcda, 4'ha, 4'h5, 4'h2, 4'h5, 6'h3e, 16'h2599},
        '{12'hd4b, 4'ha, 4'h5, 4'h3, 4'h4, 6'h23, 16'h3499},
        '{12'hebc, 4'h5, 4'ha, 4'h4, 4'h3, 6'h3e, 16'h4366},
        '{12'hf2d, 4'h5, 4'ha, 4'h5, 4'h2, 6'h23, 16'h5266},
        '{12'h09e, 4'h5, 4'ha, 4'h6, 4'h1, 6'h28, 16'h6166},
        '{12'h98f, 4'h5, 4'ha, 4'h7, 4'h0, 6'h3e, 16'h7066}};
    logic        core_clk = 1'h0;
    logic        rst = 1'h1;
    logic        dev_sel = 1'h1;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'hf;
    logic [31:0] d;
    logic [1:0]  resp;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic        arvalid = 1'h0, rready = 1'h0;
    logic [3:0]  hi = 4'h0, lo = 4'h0, fail = 4'h0, terr = 4'h0;
    wire logic   awready, wready, bvalid, arready, rvalid, irq, mx_lo, mx_hi;
    wire logic [1:0]  bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [2:0]  line, oe, unit;
    int          mismatches = 0;
    int          n_checks = 0;
    int          cycles = 0;

    tmu_regs #(.ADDR_W(8), .CHIP_INFO(16'h0000)) tmu_regs_i (
        .core_clk(core_clk), .rst(rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .comp_high(hi), .comp_low(lo),
        .fail_any(fail), .timing_err(terr),
        .measure_arm_out(line[0]), .measure_arm_oe(oe[0]),
        .measure_start_out(line[1]), .measure_start_oe(oe[1]),
        .measure_stop_out(line[2]), .measure_stop_oe(oe[2]),
        .lower_pair_mux_enable(mx_lo), .upper_pair_mux_enable(mx_hi),
        .irq(irq));

    tmu_board_sel tmu_board_sel_i (.core_clk(core_clk), .dev_sel(dev_sel),
        .line(line), .oe(oe), .unit(unit));

    // Clock at 200 MHz.
    always #2.5 core_clk = ~core_clk;

    // A hang ends the run; the ceiling is far above the expected length.
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // Address and data go out together; each drops once it is taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge core_clk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
        end while (!(bvalid && bready));
        resp = bresp;
        bready <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge core_clk);
            if (arvalid && arready) arvalid <= 1'h0;
        end while (!(rvalid && rready));
        d = rdata;
        resp = rresp;
        rready <= 1'h0;
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e,
                      input string nm);
        rd(a);
        chk(nm, d, e);
    endtask

    // Table first, then status, interrupt, multiplex, refusal and lane cases, reset last.
    initial begin
        idle(8);
        rst <= 1'h0;
        idle(2);
        foreach (rows[i]) begin
            hi <= rows[i].hi;
            lo <= rows[i].lo;
            fail <= rows[i].fail;
            terr <= rows[i].terr;
            wr(8'h70, {20'h0, rows[i].route});
            idle(3);
            chk("lines", {26'h0, oe[0], line[0], oe[1], line[1], oe[2], line[2]}, {26'h0, rows[i].outs});
            if (rows[i].outs[5]) chk("unit arm", {31'h0, unit[0]}, {31'h0, rows[i].outs[4]});
            rc(8'h70, {20'h0, rows[i].route}, "route");
            rc(8'h78, {16'h0, rows[i].stat}, "status");
        end
        chk("masked irq", {31'h0, irq}, 32'h0);
        rc(8'h78, 32'h7066, "status reread");
        fail <= 4'h0;
        terr <= 4'h0;
        idle(2);
        rc(8'h78, 32'h0066, "status cleared");
        rd(8'h80);
        wr(8'h84, 32'h01);
        fail <= 4'h8;
        idle(3);
        chk("irq masked", {31'h0, irq}, 32'h0);
        terr <= 4'h1;
        idle(3);
        chk("irq raised", {31'h0, irq}, 32'h1);
        rc(8'h80, 32'h81, "irq status");
        idle(2);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        foreach (rows[i]) begin
            if (i < 3) begin
                wr(8'h74, 32'hffff_fffc | 32'(i + 1));
                idle(1);
                chk("mux pins", {30'h0, mx_hi, mx_lo}, 32'(i + 1));
                rc(8'h74, 32'(i + 1), "mux");
            end
        end
        rd(8'h88);
        chk("unmapped read", {30'h0, resp}, {30'h0, RESP_SLVERR});
        chk("unmapped data", d, 32'h0);
        wr(8'h88, 32'h1);
        chk("unmapped write", {30'h0, resp}, {30'h0, RESP_SLVERR});
        wr(8'h78, 32'hffff);
        chk("status write", {30'h0, resp}, {30'h0, RESP_OKAY});
        rc(8'h78, 32'h8166, "status kept");
        rc(8'h7c, 32'h0, "chip info");
        // Lane 0 alone must leave the stop field of the route untouched.
        wstrb <= 4'h1;
        wr(8'h70, 32'h00000fff);
        wstrb <= 4'hf;
        rc(8'h70, 32'h000009ff, "route lane 0");
        rst <= 1'h1;
        idle(8);
        chk("lines in reset", {29'h0, oe}, 32'h0);
        rst <= 1'h0;
        idle(2);
        chk("lines after reset", {26'h0, oe, line}, 32'h0);
        chk("mux after reset", {30'h0, mx_hi, mx_lo}, 32'h0);
        rc(8'h70, 32'h0, "route reset");
        rc(8'h74, 32'h0, "mux reset");
        summarize();
    end
endmodule
`default_nettype wire
